// >>> logic/drp_pkg.sv
// Shared constants and types for the dual-rank DRAM pin interface
`default_nettype none
package drp_pkg;

  // ==========================================================
  // Geometry
  localparam int RANKS  = 2;
  localparam int DQ_MAX = 8;
  localparam int ADDR_W = 16;
  localparam int BA_W   = 3;
  localparam int PIN_W  = 37;   // Width of the sampled pin vector

  // ==========================================================
  // Mode register selects and fields
  localparam logic [2:0] MR0_SEL     = 3'h0;
  localparam logic [2:0] MR1_SEL     = 3'h1;
  localparam int         MR0_BL_LO   = 0;
  localparam int         MR0_BL_HI   = 1;
  localparam logic [1:0] MR0_BL_FIX8 = 2'h0;
  localparam logic [1:0] MR0_BL_OTF  = 2'h1;
  localparam logic [1:0] MR0_BL_BC4  = 2'h2;
  localparam int         MR1_RTT_B0  = 2;
  localparam int         MR1_RTT_B1  = 6;
  localparam int         MR1_RTT_B2  = 9;
  localparam int         MR1_TDQS    = 11;
  localparam int         ADDR_BC     = 12;
  localparam logic [3:0] BURST_8     = 4'h8;
  localparam logic [3:0] BURST_4     = 4'h4;

  // ==========================================================
  // Reset values
  localparam logic [1:0] RST_BL_MODE = MR0_BL_FIX8;
  localparam logic       RST_RTT_DIS = 1'b0;
  localparam logic       RST_TDQS_EN = 1'b0;

  // ==========================================================
  // Commands, coded as {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    DRP_CMD_MRS = 4'h0,
    DRP_CMD_REF = 4'h1,
    DRP_CMD_PRE = 4'h2,
    DRP_CMD_ACT = 4'h3,
    DRP_CMD_WR  = 4'h4,
    DRP_CMD_RD  = 4'h5,
    DRP_CMD_ZQC = 4'h6,
    DRP_CMD_NOP = 4'h7,
    DRP_CMD_DES = 4'h8
  } drp_cmd_t;

  typedef enum logic [1:0] {
    DRP_ST_IDLE = 2'h0,
    DRP_ST_WR   = 2'h1,
    DRP_ST_RD   = 2'h2
  } drp_state_t;

  // Decode one rank's command from its select and the shared strobes
  function automatic drp_cmd_t drp_decode(logic cs_n, logic ras_n,
                                          logic cas_n, logic we_n);
    return cs_n ? DRP_CMD_DES : drp_cmd_t'({1'b0, ras_n, cas_n, we_n});
  endfunction : drp_decode

endpackage : drp_pkg
`default_nettype wire

// >>> logic/drp_buf_if.sv
// Valid/ready carrier for read words between the design's modules
`timescale 1ns/1ps
`default_nettype none
interface drp_buf_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : drp_buf_if
`default_nettype wire

// >>> logic/drp_rd_buf.sv
// Small valid/ready buffer for read words
`timescale 1ns/1ps
`default_nettype none
module drp_rd_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill and drain sides
  drp_buf_if.snk   up,
  drp_buf_if.src   dn
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] next_ptr(logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : next_ptr

  // Handshake flags
  assign up.ready = (cnt_q != FULL);
  assign dn.valid = (cnt_q != '0);
  assign dn.data  = mem_q[rp_q];
  assign push     = up.valid & up.ready;
  assign pop      = dn.valid & dn.ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= up.data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= next_ptr(wp_q);
      end
      if (pop) begin
        rp_q <= next_ptr(rp_q);
      end
      cnt_q <= AW'(0) + cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_stall_hold: assert property (dn.valid && !dn.ready |=>
    dn.valid && $stable(dn.data)) else $error("stalled word not held");
  chk_fill_bound: assert property (cnt_q <= FULL)
    else $error("buffer count beyond depth");
  chk_push_count: assert property (push && !pop |=> cnt_q == $past(cnt_q) + 1)
    else $error("push did not raise fill count");

endmodule : drp_rd_buf
`default_nettype wire

// >>> logic/drp_pin_if_top.sv
// Dual-rank DRAM pin interface: command, mask, termination, strobes
//
// Notes on behaviour
// - A command is decoded only when its chip select is low; high masks it.
// - The command is the joint level of select, ras, cas and we strobes.
// - A write beat sampled with the mask high is dropped, others stored.
// - Termination follows each rank's registered on-die termination input.
// - Termination covers only the used data lines, strobes and mask ball.
// - When termination is turned off by mode load the input is ignored.
// - The active low reset asserts without the clock; release takes two clock edges.
// - Read strobe transitions coincide with read data transitions.
// - In 8-bit mode with termination strobe on, masking is disabled.
// - Width dependent balls carry upper data only in 8-bit mode.
// - Command inputs are sampled where clock rises and its pair falls.
// - With on-the-fly chop, address bit 12 high gives 8 beats, low 4.
`timescale 1ns/1ps
`default_nettype none
module drp_pin_if_top #(
  parameter bit X8    = 1'b1,
  parameter int COL_W = 4
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Differential link clock
  input  wire logic        ck,
  input  wire logic        ck_n,
  // Command bus
  input  wire logic [1:0]  cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [15:0] addr,
  input  wire logic [1:0]  odt,
  // Data bus
  input  wire logic        dm,
  input  wire logic [7:0]  dq_i,
  output logic      [7:0]  dq_o,
  output logic      [7:0]  dq_oe,
  output logic             dqs_o,
  output logic             dqs_n_o,
  output logic             dqs_oe,
  // Termination status per rank
  output logic      [1:0]  term_en,
  output logic      [1:0]  term_tdqs_en
);
  // ==========================================================
  // Width selection
  localparam logic [7:0] DQ_USED = X8 ? 8'hff : 8'h0f;

  // ==========================================================
  // Reset release
  logic rst_s1_q;
  logic rst_int_n;

  // Asynchronous assert, two-stage release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q  <= 1'b0;
      rst_int_n <= 1'b0;
    end else begin
      rst_s1_q  <= 1'b1;
      rst_int_n <= rst_s1_q;
    end
  end

  // ==========================================================
  // Pin sampling
  logic [drp_pkg::PIN_W-1:0] s1_q;
  logic [drp_pkg::PIN_W-1:0] s2_q;
  logic [drp_pkg::PIN_W-1:0] s3_q;
  logic [drp_pkg::PIN_W-1:0] lvl_q;
  logic        p_ck;
  logic        p_ckn;
  logic [1:0]  p_cs;
  logic        p_ras;
  logic        p_cas;
  logic        p_we;
  logic [2:0]  p_ba;
  logic [15:0] p_addr;
  logic [1:0]  p_odt;
  logic        p_dm;
  logic [7:0]  p_dq;

  // Three stages; a bit moves once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s1_q  <= '1;
      s2_q  <= '1;
      s3_q  <= '1;
      lvl_q <= '1;
    end else begin
      s1_q  <= {ck, ck_n, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, dq_i};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
    end
  end

  assign {p_ck, p_ckn, p_cs, p_ras, p_cas, p_we, p_ba, p_addr, p_odt,
          p_dm, p_dq} = lvl_q;

  // ==========================================================
  // Clock crossing detection
  logic crs_r;
  logic crs_f;
  logic crs_r_q;
  logic crs_f_q;
  logic rise;
  logic edge_any;

  assign crs_r    = p_ck & ~p_ckn;
  assign crs_f    = ~p_ck & p_ckn;
  assign rise     = crs_r & ~crs_r_q;
  assign edge_any = rise | (crs_f & ~crs_f_q);

  // Previous crossing levels
  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      crs_r_q <= 1'b0;
      crs_f_q <= 1'b0;
    end else begin
      crs_r_q <= crs_r;
      crs_f_q <= crs_f;
    end
  end

  // ==========================================================
  // Command decode
  drp_pkg::drp_cmd_t cmd_r [drp_pkg::RANKS];
  drp_pkg::drp_cmd_t cmd_sel;
  logic              sel_rank;

  // Each rank sees its own select with the shared strobes
  always_comb begin
    for (int r = 0; r < drp_pkg::RANKS; r++) begin
      cmd_r[r] = drp_pkg::drp_decode(p_cs[r], p_ras, p_cas, p_we);
    end
  end

  assign sel_rank = p_cs[0];
  assign cmd_sel  = cmd_r[sel_rank];

  // ==========================================================
  // Mode state per rank
  logic [1:0] bl_mode_q [drp_pkg::RANKS];
  logic [1:0] rtt_dis_q;
  logic [1:0] tdqs_en_q;

  // Mode register loads
  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      for (int r = 0; r < drp_pkg::RANKS; r++) begin
        bl_mode_q[r] <= drp_pkg::RST_BL_MODE;
        rtt_dis_q[r] <= drp_pkg::RST_RTT_DIS;
        tdqs_en_q[r] <= drp_pkg::RST_TDQS_EN;
      end
    end else if (rise) begin
      for (int r = 0; r < drp_pkg::RANKS; r++) begin
        if (cmd_r[r] == drp_pkg::DRP_CMD_MRS) begin
          if (p_ba == drp_pkg::MR0_SEL) begin
            bl_mode_q[r] <= p_addr[drp_pkg::MR0_BL_HI:drp_pkg::MR0_BL_LO];
          end else if (p_ba == drp_pkg::MR1_SEL) begin
            rtt_dis_q[r] <= ~(p_addr[drp_pkg::MR1_RTT_B0] |
                              p_addr[drp_pkg::MR1_RTT_B1] |
                              p_addr[drp_pkg::MR1_RTT_B2]);
            tdqs_en_q[r] <= X8 & p_addr[drp_pkg::MR1_TDQS];
          end
        end
      end
    end
  end

  // ==========================================================
  // Termination
  logic [1:0] term_q;
  logic [1:0] term_tdqs_q;

  // Registered on each rising crossing
  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      term_q      <= '0;
      term_tdqs_q <= '0;
    end else if (rise) begin
      term_q      <= p_odt & ~rtt_dis_q;
      term_tdqs_q <= p_odt & ~rtt_dis_q & tdqs_en_q;
    end
  end

  assign term_en      = term_q;
  assign term_tdqs_en = term_tdqs_q;

  // ==========================================================
  // Burst sequencing
  drp_pkg::drp_state_t st_q;
  logic                rank_q;
  logic [COL_W-1:0]    col_q;
  logic [3:0]          len_q;
  logic [3:0]          beat_q;
  logic [3:0]          bl;
  logic                start_wr;
  logic                start_rd;
  logic                last_beat;

  // Burst length from mode and chop bit
  always_comb begin
    unique case (bl_mode_q[sel_rank])
      drp_pkg::MR0_BL_OTF: bl = p_addr[drp_pkg::ADDR_BC] ?
                                drp_pkg::BURST_8 : drp_pkg::BURST_4;
      drp_pkg::MR0_BL_BC4: bl = drp_pkg::BURST_4;
      default:             bl = drp_pkg::BURST_8;
    endcase
  end

  assign start_wr  = rise && st_q == drp_pkg::DRP_ST_IDLE &&
                     cmd_sel == drp_pkg::DRP_CMD_WR;
  assign start_rd  = rise && st_q == drp_pkg::DRP_ST_IDLE &&
                     cmd_sel == drp_pkg::DRP_CMD_RD;
  assign last_beat = (beat_q == len_q - 4'h1);

  drp_buf_if #(.W(8)) rd_in ();
  drp_buf_if #(.W(8)) rd_out ();

  // Burst state machine
  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_q   <= drp_pkg::DRP_ST_IDLE;
      rank_q <= 1'b0;
      col_q  <= '0;
      len_q  <= drp_pkg::BURST_8;
      beat_q <= '0;
    end else begin
      unique case (st_q)
        drp_pkg::DRP_ST_IDLE: begin
          if (start_wr || start_rd) begin
            st_q   <= start_wr ? drp_pkg::DRP_ST_WR : drp_pkg::DRP_ST_RD;
            rank_q <= sel_rank;
            col_q  <= p_addr[COL_W-1:0];
            len_q  <= bl;
            beat_q <= '0;
          end
        end
        drp_pkg::DRP_ST_WR: begin
          if (edge_any) begin
            beat_q <= beat_q + 4'h1;
            st_q   <= last_beat ? drp_pkg::DRP_ST_IDLE : st_q;
          end
        end
        drp_pkg::DRP_ST_RD: begin
          if (rd_in.valid && rd_in.ready) begin
            beat_q <= beat_q + 4'h1;
            st_q   <= last_beat ? drp_pkg::DRP_ST_IDLE : st_q;
          end
        end
        default: st_q <= drp_pkg::DRP_ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Storage and write masking
  logic [7:0]     mem_q [2**(COL_W+1)];
  logic [COL_W:0] idx;
  logic           mask_on;
  logic           wr_beat;
  logic           wr_en;

  assign idx     = {rank_q, col_q + COL_W'(beat_q)};
  assign mask_on = ~tdqs_en_q[rank_q];
  assign wr_beat = (st_q == drp_pkg::DRP_ST_WR) && edge_any;
  assign wr_en   = wr_beat && !(p_dm && mask_on);

  // Array write, one beat per crossing
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_q[idx] <= p_dq & DQ_USED;
    end
  end

  // ==========================================================
  // Read path
  assign rd_in.data   = mem_q[idx];
  assign rd_in.valid  = (st_q == drp_pkg::DRP_ST_RD);
  assign rd_out.ready = edge_any;

  drp_rd_buf #(.W(8), .DEPTH(2)) u_rd_buf (
    .clk   (sys_clk),
    .rst_n (rst_int_n),
    .up    (rd_in),
    .dn    (rd_out)
  );

  // Drive one beat per crossing with a strobe toggle
  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      dq_o    <= '0;
      dq_oe   <= '0;
      dqs_o   <= 1'b0;
      dqs_n_o <= 1'b1;
      dqs_oe  <= 1'b0;
    end else if (edge_any) begin
      if (rd_out.valid) begin
        dq_o    <= rd_out.data & DQ_USED;
        dq_oe   <= DQ_USED;
        dqs_o   <= ~dqs_o;
        dqs_n_o <= dqs_o;
        dqs_oe  <= 1'b1;
      end else begin
        dq_oe   <= '0;
        dqs_o   <= 1'b0;
        dqs_n_o <= 1'b1;
        dqs_oe  <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_int_n);

  sequence s_idle_rise;
    rise && st_q == drp_pkg::DRP_ST_IDLE;
  endsequence
  sequence s_wr_cmd0;
    s_idle_rise ##0 !p_cs[0] && {p_ras, p_cas, p_we} == 3'b100;
  endsequence
  sequence s_masked_beat;
    wr_beat && p_dm && mask_on;
  endsequence

  chk_desel_ignored: assert property (s_idle_rise ##0 (&p_cs) |=>
    st_q == drp_pkg::DRP_ST_IDLE) else $error("deselected command acted");
  chk_wr_decode: assert property (s_wr_cmd0 |=>
    st_q == drp_pkg::DRP_ST_WR && !rank_q) else $error("write not decoded");
  chk_odt_follow: assert property (rise |=>
    term_q == $past(p_odt & ~rtt_dis_q)) else $error("termination mismatch");
  chk_odt_ignored: assert property (rise && rtt_dis_q[0] |=>
    !term_q[0]) else $error("termination on while disabled");
  chk_mask_keep: assert property (s_masked_beat |=>
    mem_q[$past(idx)] == $past(mem_q[idx])) else $error("masked beat stored");
  chk_tdqs_only_x8: assert property (term_tdqs_q[0] |->
    term_q[0] && X8) else $error("termination strobe misused");
  chk_strobe_align: assert property ($changed(dq_o) |->
    $changed(dqs_o) && dqs_oe) else $error("data moved without strobe");
  chk_chop_len: assert property ((start_wr || start_rd) &&
    bl_mode_q[sel_rank] == drp_pkg::MR0_BL_OTF |=>
    len_q == ($past(p_addr[drp_pkg::ADDR_BC]) ? 4'h8 : 4'h4))
    else $error("chop length wrong");
  chk_upper_quiet: assert property (dq_oe ==
    (dqs_oe ? DQ_USED : 8'h00)) else $error("lane enables wrong for width");

endmodule : drp_pin_if_top
`default_nettype wire

// >>> dv/drp_ctl_model.sv
// Controller-side model that drives the link and gathers read beats
`timescale 1ns/1ps
`default_nettype none
module drp_ctl_model (
  // Clock
  input  wire logic        sys_clk,
  // Link clock and command bus
  output logic             ck,
  output logic             ck_n,
  output logic      [1:0]  cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic      [2:0]  ba,
  output logic      [15:0] addr,
  output logic      [1:0]  odt,
  // Write data and mask
  output logic             dm,
  output logic      [7:0]  dq_i,
  // Read side from the device
  input  wire logic [7:0]  dq_o,
  input  wire logic [7:0]  dq_oe,
  input  wire logic        dqs_o,
  input  wire logic        dqs_n_o,
  input  wire logic        dqs_oe
);
  // ==========================================================
  // Read capture state
  logic [7:0] rd_q [$];
  logic       dqs_p_q  = 1'b0;
  logic       oe_p_q   = 1'b0;
  int         pair_bad = 0;

  // Idle link: clock parked low, both ranks deselected
  initial begin
    {ck, ck_n, cs_n, ras_n, cas_n, we_n} = 7'h3f;
    {ba, addr, odt, dm, dq_i} = 30'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // ==========================================================
  // One command at a rising crossing, then eleven crossings of burst
  task automatic send(input logic [1:0] cs, input drp_pkg::drp_cmd_t c,
                      input logic [2:0] b, input logic [15:0] a,
                      input logic [1:0] o, input int beats,
                      input logic [63:0] wd, input logic [7:0] wm);
    rd_q.delete();
    @(posedge sys_clk);
    {cs_n, ras_n, cas_n, we_n} <= {cs, c[2:0]};
    {ba, addr, odt} <= {b, a, o};
    tick(4);
    {ck, ck_n} <= 2'b10;  // Command stable across the crossing
    tick(2);
    cs_n <= 2'b11;  // Later rises carry no command
    for (int k = 0; k < 11; k++) begin
      // Data changes mid-beat; released lines flip
      if (k < beats) {dm, dq_i} <= {wm[k], wd[8*k +: 8]};
      else {dm, dq_i} <= ~{dm, dq_i};
      tick(2);
      {ck, ck_n} <= ~{ck, ck_n};
      tick(2);
    end
    tick(8);
  endtask : send

  // Take a beat on each strobe edge; flag a broken pair or lane enable
  always @(posedge sys_clk) begin
    if (dqs_oe === 1'b1 && (oe_p_q !== 1'b1 || dqs_o !== dqs_p_q))
      rd_q.push_back(dq_o);
    if (dqs_oe === 1'b1 && (dqs_n_o !== ~dqs_o || dq_oe !== 8'hff))
      pair_bad++;
    dqs_p_q <= dqs_o;
    oe_p_q  <= dqs_oe;
  end
endmodule : drp_ctl_model
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the dual-rank DRAM pin interface
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // Pins, counters and patterns
  logic        sys_clk, rst_n, ck, ck_n, ras_n, cas_n, we_n, dm;
  logic        dqs_o, dqs_n_o, dqs_oe;
  logic [1:0]  cs_n, odt, term_en, term_tdqs_en;
  logic [2:0]  ba;
  logic [15:0] addr;
  logic [7:0]  dq_i, dq_o, dq_oe;
  logic [63:0] rv;
  int          rn;
  int          err_count = 0;
  int          samples_checked = 0;
  localparam logic [63:0] PAT_A = 64'h1122334455667788;
  localparam logic [63:0] PAT_B = 64'haabbccddeeff0099;
  localparam logic [63:0] PAT_C = 64'h0f1e2d3c4b5a6978;
  // Odd beats keep the first pattern under mask 8'haa
  localparam logic [63:0] MERGED = 64'h11bb33dd55ff7799;

  drp_pin_if_top #(.X8(1'b1), .COL_W(4)) dut (
    .sys_clk, .rst_n, .ck, .ck_n, .cs_n, .ras_n, .cas_n, .we_n, .ba,
    .addr, .odt, .dm, .dq_i, .dq_o, .dq_oe, .dqs_o, .dqs_n_o, .dqs_oe,
    .term_en, .term_tdqs_en
  );
  drp_ctl_model ctl (
    .sys_clk, .ck, .ck_n, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
    .odt, .dm, .dq_i, .dq_o, .dq_oe, .dqs_o, .dqs_n_o, .dqs_oe
  );

  // 20 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic cmd(input drp_pkg::drp_cmd_t c, input logic [2:0] b,
                     input logic [15:0] a, input logic [1:0] o);
    ctl.send(2'b00, c, b, a, o, 0, 64'h0, 8'h0);
  endtask : cmd

  task automatic wr(input logic [1:0] cs, input logic [15:0] a,
                    input logic [63:0] d, input logic [7:0] m);
    ctl.send(cs, drp_pkg::DRP_CMD_WR, 3'h0, a, 2'b00, 8, d, m);
  endtask : wr

  task automatic rd(input logic [1:0] cs, input logic [15:0] a);
    ctl.send(cs, drp_pkg::DRP_CMD_RD, 3'h0, a, 2'b00, 0, 64'h0, 8'h0);
    rn = ctl.rd_q.size();
    rv = 64'h0;
    for (int k = 0; k < rn && k < 8; k++) rv[8*k +: 8] = ctl.rd_q[k];
  endtask : rd

  // ==========================================================
  // Scenarios
  task automatic t_mask();
    wr(2'b10, 16'h0000, PAT_A, 8'h00);
    wr(2'b10, 16'h0000, PAT_B, 8'haa);
    wr(2'b01, 16'h0000, PAT_C, 8'h00);
    wr(2'b11, 16'h0000, ~PAT_C, 8'h00);
    rd(2'b10, 16'h0000);
    check("rank0 data", rv, MERGED);
    rd(2'b01, 16'h0000);
    check("rank1 data", rv, PAT_C);
    check("oe released", 64'({dqs_oe, dqs_n_o, dq_oe}), 64'h100);
    $display("test mask done");
  endtask : t_mask

  task automatic t_burst();
    logic [1:0] md [5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
    logic       hi [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    int         n  [5] = '{4, 8, 4, 8, 8};
    for (int i = 0; i < 5; i++) begin
      cmd(drp_pkg::DRP_CMD_MRS, 3'h0, {14'h0, md[i]}, 2'b00);
      rd(2'b10, {3'h0, hi[i], 12'h0});
      check("burst beats", 64'(rn), 64'(n[i]));
      check("burst data", rv,
            (n[i] == 4) ? {32'h0, MERGED[31:0]} : MERGED);
    end
    $display("test burst done");
  endtask : t_burst

  task automatic t_odt();
    logic [7:0] seq = 8'h2d;
    for (int i = 0; i < 4; i++) begin
      cmd(drp_pkg::DRP_CMD_NOP, 3'h0, 16'h0, seq[2*i +: 2]);
      check("term on", 64'(term_en), 64'(seq[2*i +: 2]));
      check("tdqs off", 64'(term_tdqs_en), 64'h0);
    end
    $display("test odt done");
  endtask : t_odt

  task automatic t_term();
    cmd(drp_pkg::DRP_CMD_MRS, 3'h1, 16'h0804, 2'b00);
    cmd(drp_pkg::DRP_CMD_NOP, 3'h0, 16'h0, 2'b11);
    check("tdqs term", 64'(term_tdqs_en), 64'h3);
    wr(2'b10, 16'h0008, PAT_A, 8'hff);
    rd(2'b10, 16'h0008);
    check("mask off", rv, PAT_A);
    cmd(drp_pkg::DRP_CMD_MRS, 3'h1, 16'h0000, 2'b00);
    cmd(drp_pkg::DRP_CMD_NOP, 3'h0, 16'h0, 2'b11);
    check("odt ignored", 64'({term_en, term_tdqs_en}), 64'h0);
    check("strobe pairs", 64'(ctl.pair_bad), 64'h0);
    $display("test term done");
  endtask : t_term

  task automatic t_reset();
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      rst_n <= 1'b0;
      #1;
      if (i == 1) check("async reset", 64'(term_en), 64'h0);
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      if (i == 0) cmd(drp_pkg::DRP_CMD_NOP, 3'h0, 16'h0, 2'b11);
      if (i == 0) check("mode restored", 64'(term_en), 64'h3);
    end
    $display("test reset done");
  endtask : t_reset

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    check("reset pins", 64'({dq_o, dq_oe, dqs_oe, dqs_n_o, term_en,
          term_tdqs_en}), 64'h10);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_mask();
    t_burst();
    t_odt();
    t_term();
    t_reset();
    close_out();
  end

  initial begin
    repeat (12000) @(posedge sys_clk);
    err_count++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
